//--- common/nco_pkg.sv
// Constants shared by the dual-channel oscillator files.
package nco_pkg;
	localparam int ADDR_W = 6;
	localparam int TUNE_W = 32;
	localparam int OFFS_W = 16;
	localparam int DITH_W = 5;
	localparam int SEL_W = 3;
	localparam int OUT_W = 20;
	localparam int PH_W = OFFS_W + DITH_W;
	localparam int LUT_IDX_W = 6;
	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_SSEL = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_TUNE_A_LO = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_TUNE_A_HI = 6'h0c;
	localparam logic [ADDR_W-1:0] OFF_TUNE_B_LO = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_TUNE_B_HI = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_OFFS_A = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_OFFS_B = 6'h1c;
	localparam logic [ADDR_W-1:0] OFF_ACC_A = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_DITH_ST = 6'h24;
	// Control register fields
	localparam int CTRL_DUAL = 0;
	localparam int CTRL_DITH_ON = 1;
	localparam int CTRL_TRIM_LO = 2;
	localparam int CTRL_SW_SYNC = 4;
	// Sync selector fields
	localparam int SSEL_CLR = 0;
	localparam int SSEL_DITH = 4;
	localparam int SSEL_FREQ = 8;
	localparam int SSEL_PHASE = 12;
	// Sync source codes
	localparam logic [SEL_W-1:0] SRC_NEVER = 3'h0;
	localparam logic [SEL_W-1:0] SRC_ALWAYS = 3'h1;
	localparam int SRC_EXT_N = 5;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SSEL_RST = 32'h0000_0000;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : nco_pkg

//--- core/nco_sync_sel.sv
// One sync-source selector: picks the event that triggers one function.
`timescale 1ns/1ps
`default_nettype none
module nco_sync_sel #(
	parameter int SEL_W = 3
) (
	input wire logic [SEL_W-1:0] sel,
	input wire logic [(1<<SEL_W)-1:0] sources,
	output logic event_hit
);
	always_comb begin
		event_hit = sources[sel];
	end
endmodule : nco_sync_sel
`default_nettype wire

//--- core/nco_sincos.sv
// Quarter-wave sine/cosine table indexed by the top phase bits.
`timescale 1ns/1ps
`default_nettype none
module nco_sincos #(
	parameter int IDX_W = 6,
	parameter int OUT_W = 20
) (
	input wire logic [IDX_W-1:0] phase_idx,
	output logic signed [OUT_W-1:0] sin_val,
	output logic signed [OUT_W-1:0] cos_val
);
	function automatic logic signed [OUT_W-1:0] quarter(input logic [4:0] k);
		logic [19:0] v;
		v = 20'h00000;
		unique case (k)
			5'h00: v = 20'h00000;
			5'h01: v = 20'h0c8bd;
			5'h02: v = 20'h18f8c;
			5'h03: v = 20'h25281;
			5'h04: v = 20'h30fbc;
			5'h05: v = 20'h3c56b;
			5'h06: v = 20'h471ce;
			5'h07: v = 20'h5133c;
			5'h08: v = 20'h5a827;
			5'h09: v = 20'h62f1f;
			5'h0a: v = 20'h6a6d9;
			5'h0b: v = 20'h70e2c;
			5'h0c: v = 20'h76420;
			5'h0d: v = 20'h7a7d5;
			5'h0e: v = 20'h7d8a5;
			5'h0f: v = 20'h7f622;
			default: v = 20'h7ffff;
		endcase
		return OUT_W'(signed'(v));
	endfunction : quarter

	// Sine of a 6-bit angle, one quadrant mirrored four ways
	function automatic logic signed [OUT_W-1:0] sine(input logic [IDX_W-1:0] p);
		logic [4:0] i;
		logic signed [OUT_W-1:0] m;
		i = {1'b0, p[3:0]};
		m = p[4] ? quarter(5'h10 - i) : quarter(i);
		return p[5] ? -m : m;
	endfunction : sine

	always_comb begin
		sin_val = sine(phase_idx);
		cos_val = sine(phase_idx + IDX_W'(16));
	end
endmodule : nco_sincos
`default_nettype wire

//--- core/nco_core.sv
// Dual-channel complex oscillator with sync-loaded words and AXI4-Lite registers.
// Function
// - Accumulate tuning word, table lookup each sample
// - Add 16-bit phase offset before lookup
// - Inject 5-bit dither below phase LSBs
// - Dither only while dither-on bit set
// - Trim bits zero top two dither bits
// - Tuning word assembled from two halves
// - Resolution is clock over two to 32
// - Tuning word is signed, wraps naturally
// - B tuning word used only in dual
// - B offset used only in dual
// - Tuning word takes effect on sync
// - Phase offset loads on phase sync
// - Accumulator-clear sync zeroes the accumulator
// - Dither-reset sync reseeds the generator
// - Four functions, each own 3-bit selector
// - One sync set shared by A and B
// - Sine and cosine outputs 20 bits
// - Dual-mode bit selects two channels or one
`timescale 1ns/1ps
`default_nettype none
module nco_core #(
	parameter int ADDR_W = nco_pkg::ADDR_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [nco_pkg::SRC_EXT_N-1:0] sync_in,
	output logic signed [nco_pkg::OUT_W-1:0] sin_a,
	output logic signed [nco_pkg::OUT_W-1:0] cos_a,
	output logic signed [nco_pkg::OUT_W-1:0] sin_b,
	output logic signed [nco_pkg::OUT_W-1:0] cos_b
);
	localparam int TW = nco_pkg::TUNE_W;
	localparam int OW = nco_pkg::OFFS_W;
	localparam int PW = nco_pkg::PH_W;
	localparam int DW = nco_pkg::DITH_W;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// Bus slave state
	logic aw_full_r, w_full_r, awrdy_r, wrdy_r, bvalid_r, arrdy_r, rvalid_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic aw_full_nxt, w_full_nxt, rvalid_nxt, do_wr;

	// Software-visible registers
	logic [31:0] ctrl_r, ssel_r;
	logic [TW-1:0] tsh_a_r, tsh_b_r;
	logic [OW-1:0] osh_a_r, osh_b_r;
	logic sw_sync_r;

	// Oscillator state
	logic [TW-1:0] tune_a_r, tune_b_r, acc_a_r, acc_b_r;
	logic [OW-1:0] offs_a_r, offs_b_r;
	logic [15:0] lfsr_r;
	logic [DW-1:0] dither;
	logic [PW-1:0] ph_a, ph_b;
	logic signed [nco_pkg::OUT_W-1:0] lut_sin_a, lut_cos_a, lut_sin_b, lut_cos_b;
	logic [7:0] sync_src;
	logic clr_ev, dth_ev, frq_ev, phs_ev;
	logic dual_r, dith_on_r;
	logic [1:0] trim_r;

	assign dual_r = ctrl_r[nco_pkg::CTRL_DUAL];
	assign dith_on_r = ctrl_r[nco_pkg::CTRL_DITH_ON];
	assign trim_r = ctrl_r[nco_pkg::CTRL_TRIM_LO +: 2];

	// Write channel acceptance, address and data in either order
	always_comb begin
		do_wr = aw_full_r && w_full_r && !bvalid_r;
		aw_full_nxt = (aw_full_r && !do_wr) || (s_axi_awvalid && awrdy_r);
		w_full_nxt = (w_full_r && !do_wr) || (s_axi_wvalid && wrdy_r);
		rvalid_nxt = (rvalid_r && !s_axi_rready) || (s_axi_arvalid && arrdy_r);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awrdy_r <= 1'b0;
			wrdy_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awrdy_r <= !aw_full_nxt;
			wrdy_r <= !w_full_nxt;
			if (s_axi_awvalid && awrdy_r) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wrdy_r) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bvalid_r <= 1'b0;
			bresp_r <= nco_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_r <= 1'b1;
			bresp_r <= (awaddr_r <= nco_pkg::OFF_OFFS_B && awaddr_r[1:0] == 2'h0) ?
				nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Register writes; the tuning word is built from two 16-bit halves
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= nco_pkg::CTRL_RST;
			ssel_r <= nco_pkg::SSEL_RST;
			tsh_a_r <= '0;
			tsh_b_r <= '0;
			osh_a_r <= '0;
			osh_b_r <= '0;
			sw_sync_r <= 1'b0;
		end else begin
			sw_sync_r <= 1'b0;
			if (do_wr) begin
				unique case (awaddr_r)
					nco_pkg::OFF_CTRL: begin
						ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_000f;
						sw_sync_r <= wstrb_r[0] && wdata_r[nco_pkg::CTRL_SW_SYNC];
					end
					nco_pkg::OFF_SSEL: ssel_r <= merge(ssel_r, wdata_r, wstrb_r) & 32'h0000_7777;
					nco_pkg::OFF_TUNE_A_LO: tsh_a_r[15:0] <= wdata_r[15:0];
					nco_pkg::OFF_TUNE_A_HI: tsh_a_r[31:16] <= wdata_r[15:0];
					nco_pkg::OFF_TUNE_B_LO: tsh_b_r[15:0] <= wdata_r[15:0];
					nco_pkg::OFF_TUNE_B_HI: tsh_b_r[31:16] <= wdata_r[15:0];
					nco_pkg::OFF_OFFS_A: osh_a_r <= wdata_r[OW-1:0];
					nco_pkg::OFF_OFFS_B: osh_b_r <= wdata_r[OW-1:0];
					default: ;
				endcase
			end
		end
	end

	// Read channel
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_r <= 1'b0;
			arrdy_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= nco_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			arrdy_r <= !rvalid_nxt;
			if (s_axi_arvalid && arrdy_r) begin
				rresp_r <= nco_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					nco_pkg::OFF_CTRL: rdata_r <= ctrl_r;
					nco_pkg::OFF_SSEL: rdata_r <= ssel_r;
					nco_pkg::OFF_TUNE_A_LO: rdata_r <= {16'h0000, tsh_a_r[15:0]};
					nco_pkg::OFF_TUNE_A_HI: rdata_r <= {16'h0000, tsh_a_r[31:16]};
					nco_pkg::OFF_TUNE_B_LO: rdata_r <= {16'h0000, tsh_b_r[15:0]};
					nco_pkg::OFF_TUNE_B_HI: rdata_r <= {16'h0000, tsh_b_r[31:16]};
					nco_pkg::OFF_OFFS_A: rdata_r <= {16'h0000, osh_a_r};
					nco_pkg::OFF_OFFS_B: rdata_r <= {16'h0000, osh_b_r};
					nco_pkg::OFF_ACC_A: rdata_r <= acc_a_r;
					nco_pkg::OFF_DITH_ST: rdata_r <= {16'h0000, lfsr_r};
					default: begin
						rdata_r <= 32'h0000_0000;
						rresp_r <= nco_pkg::RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Sync sources: never, always, five external pins, software pulse
	assign sync_src = {sw_sync_r, sync_in, 1'b1, 1'b0};

	nco_sync_sel #(.SEL_W(nco_pkg::SEL_W)) u_sel_clr (
		.sel(ssel_r[nco_pkg::SSEL_CLR +: 3]),
		.sources(sync_src),
		.event_hit(clr_ev)
	);
	nco_sync_sel #(.SEL_W(nco_pkg::SEL_W)) u_sel_dth (
		.sel(ssel_r[nco_pkg::SSEL_DITH +: 3]),
		.sources(sync_src),
		.event_hit(dth_ev)
	);
	nco_sync_sel #(.SEL_W(nco_pkg::SEL_W)) u_sel_frq (
		.sel(ssel_r[nco_pkg::SSEL_FREQ +: 3]),
		.sources(sync_src),
		.event_hit(frq_ev)
	);
	nco_sync_sel #(.SEL_W(nco_pkg::SEL_W)) u_sel_phs (
		.sel(ssel_r[nco_pkg::SSEL_PHASE +: 3]),
		.sources(sync_src),
		.event_hit(phs_ev)
	);

	// Working words change only on their sync events
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tune_a_r <= '0;
			tune_b_r <= '0;
		end else if (frq_ev) begin
			tune_a_r <= tsh_a_r;
			tune_b_r <= tsh_b_r;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			offs_a_r <= '0;
			offs_b_r <= '0;
		end else if (phs_ev) begin
			offs_a_r <= osh_a_r;
			offs_b_r <= osh_b_r;
		end
	end

	// Phase accumulators, modulo two to 32, signed step
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_a_r <= '0;
			acc_b_r <= '0;
		end else if (clr_ev) begin
			acc_a_r <= '0;
			acc_b_r <= '0;
		end else begin
			acc_a_r <= acc_a_r + tune_a_r;
			acc_b_r <= acc_b_r + (dual_r ? tune_b_r : tune_a_r);
		end
	end

	// Dither: x^16+x^14+x^13+x^11+1 Fibonacci register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lfsr_r <= nco_pkg::LFSR_SEED;
		end else if (dth_ev) begin
			lfsr_r <= nco_pkg::LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end
	end

	always_comb begin
		dither = dith_on_r ? lfsr_r[DW-1:0] : '0;
		dither[DW-1] = dither[DW-1] && !trim_r[1];
		dither[DW-2] = dither[DW-2] && !trim_r[0];
		ph_a = {acc_a_r[TW-1 -: OW] + offs_a_r, acc_a_r[TW-OW-1 -: DW]} + PW'(dither);
		ph_b = {acc_b_r[TW-1 -: OW] + (dual_r ? offs_b_r : offs_a_r),
			acc_b_r[TW-OW-1 -: DW]} + PW'(dither);
	end

	nco_sincos #(.IDX_W(nco_pkg::LUT_IDX_W), .OUT_W(nco_pkg::OUT_W)) u_lut_a (
		.phase_idx(ph_a[PW-1 -: nco_pkg::LUT_IDX_W]),
		.sin_val(lut_sin_a),
		.cos_val(lut_cos_a)
	);
	nco_sincos #(.IDX_W(nco_pkg::LUT_IDX_W), .OUT_W(nco_pkg::OUT_W)) u_lut_b (
		.phase_idx(ph_b[PW-1 -: nco_pkg::LUT_IDX_W]),
		.sin_val(lut_sin_b),
		.cos_val(lut_cos_b)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sin_a <= '0;
			cos_a <= '0;
			sin_b <= '0;
			cos_b <= '0;
		end else begin
			sin_a <= lut_sin_a;
			cos_a <= lut_cos_a;
			sin_b <= lut_sin_b;
			cos_b <= lut_cos_b;
		end
	end

	assign s_axi_awready = awrdy_r;
	assign s_axi_wready = wrdy_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arrdy_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	chk_acc_step: assert property (@(posedge clk) disable iff (!rstn)
		!clr_ev |=> acc_a_r == $past(acc_a_r) + $past(tune_a_r))
		else $error("accumulator did not advance by tuning word");
	chk_acc_clear: assert property (@(posedge clk) disable iff (!rstn)
		clr_ev |=> acc_a_r == '0 && acc_b_r == '0)
		else $error("accumulator not cleared on sync");
	chk_freq_hold: assert property (@(posedge clk) disable iff (!rstn)
		!frq_ev |=> $stable(tune_a_r) && $stable(tune_b_r))
		else $error("tuning word changed without sync");
	chk_freq_load: assert property (@(posedge clk) disable iff (!rstn)
		frq_ev |=> tune_a_r == $past(tsh_a_r))
		else $error("tuning word not loaded on sync");
	chk_phase_load: assert property (@(posedge clk) disable iff (!rstn)
		phs_ev |=> offs_a_r == $past(osh_a_r) ##0 offs_b_r == $past(osh_b_r))
		else $error("phase offset not loaded on sync");
	chk_dither_off: assert property (@(posedge clk) disable iff (!rstn)
		!dith_on_r |-> dither == '0)
		else $error("dither present while disabled");
	chk_dither_trim: assert property (@(posedge clk) disable iff (!rstn)
		(trim_r[1] |-> !dither[DW-1]) and (trim_r[0] |-> !dither[DW-2]))
		else $error("trimmed dither bit set");
	chk_lfsr_seed: assert property (@(posedge clk) disable iff (!rstn)
		dth_ev |=> lfsr_r == nco_pkg::LFSR_SEED)
		else $error("dither generator not reseeded");
	chk_lfsr_live: assert property (@(posedge clk) disable iff (!rstn)
		lfsr_r != 16'h0000)
		else $error("dither register stuck at zero");
	chk_lfsr_reset: assert property (@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> lfsr_r == nco_pkg::LFSR_SEED)
		else $error("dither register not seeded by reset");
	chk_single_b: assert property (@(posedge clk) disable iff (!rstn)
		!dual_r && !clr_ev |=> acc_b_r == $past(acc_b_r) + $past(tune_a_r))
		else $error("single mode B path not following A word");
	chk_wr_resp: assert property (@(posedge clk) disable iff (!rstn)
		do_wr |=> bvalid_r)
		else $error("write response missing");

	cov_freq_load: cover property (@(posedge clk) disable iff (!rstn) frq_ev && tsh_a_r != tune_a_r);
	cov_acc_clear: cover property (@(posedge clk) disable iff (!rstn) clr_ev ##1 !clr_ev);
	cov_dual_dith: cover property (@(posedge clk) disable iff (!rstn) dual_r && dith_on_r);
	cov_wr_rd: cover property (@(posedge clk) disable iff (!rstn) do_wr ##[1:8] rvalid_r);
endmodule : nco_core
`default_nettype wire

//--- dv/nco_mixer_model.sv
// Complex mixer model that consumes the oscillator's sine and cosine samples.
`timescale 1ns/1ps
`default_nettype none
module nco_mixer_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic signed [17:0] i_in,
	input wire logic signed [17:0] q_in,
	input wire logic signed [nco_pkg::OUT_W-1:0] sin_v,
	input wire logic signed [nco_pkg::OUT_W-1:0] cos_v,
	output logic signed [38:0] i_out,
	output logic signed [38:0] q_out
);
	// Full-precision product, one register stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			i_out <= '0;
			q_out <= '0;
		end else begin
			i_out <= i_in * cos_v + q_in * sin_v;
			q_out <= q_in * cos_v - i_in * sin_v;
		end
	end
endmodule : nco_mixer_model
`default_nettype wire

//--- dv/dual_channel_nco_bench.sv
// Self-checking bench for the dual-channel oscillator.
`timescale 1ns/1ps
`default_nettype none
module dual_channel_nco_bench;
	typedef struct {logic [15:0] offs; logic signed [19:0] s; logic signed [19:0] c;} nco_row_t;
	nco_row_t rows [4] = '{'{16'h0000, 20'h00000, 20'h7ffff}, '{16'h4000, 20'h7ffff, 20'h00000},
		'{16'h8000, 20'h00000, 20'h80001}, '{16'hc000, 20'h80001, 20'h00000}};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] awa = 6'h00, ara = 6'h00;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'hf;
	logic [4:0] sync = 5'h00;
	logic awr, wr_rdy, bv, arr, rv;
	logic [1:0] bp, rp, r;
	logic [31:0] rdat, v;
	logic signed [19:0] sa, ca, sb, cb;
	logic signed [17:0] mi = 18'h00001;
	logic signed [17:0] mq = 18'h00000;
	logic signed [38:0] mo;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #25 clk = ~clk;

	nco_core DUT (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(bp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rp), .s_axi_rvalid(rv), .s_axi_rready(rr), .sync_in(sync),
		.sin_a(sa), .cos_a(ca), .sin_b(sb), .cos_b(cb));

	nco_mixer_model mixer (.clk(clk), .rstn(rstn), .i_in(mi), .q_in(mq), .sin_v(sa),
		.cos_v(ca), .i_out(mo), .q_out());

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge clk);
			if (!ad && awr) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (!dd && wr_rdy) begin
				dd = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (!bv);
		r = bp;
		br <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		while (!rv) @(posedge clk);
		v = rdat;
		r = rp;
		rr <= 1'b0;
	endtask : rd

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			close_out();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(nco_pkg::OFF_CTRL);
		chk(v, nco_pkg::CTRL_RST);
		rd(nco_pkg::OFF_SSEL);
		chk(v, nco_pkg::SSEL_RST);
		rd(nco_pkg::OFF_DITH_ST);
		chk({v[31:16], 15'h0000, v[15:0] == 16'h0000}, 32'h0000_0000);
		chk(ca, rows[0].c);
		// New word held back until the software sync pulse
		wr(nco_pkg::OFF_TUNE_A_LO, 32'h0000_0000);
		wr(nco_pkg::OFF_TUNE_A_HI, 32'h0000_0100);
		rd(nco_pkg::OFF_TUNE_A_HI);
		chk(v, 32'h0000_0100);
		rd(nco_pkg::OFF_ACC_A);
		chk(v, 32'h0000_0000);
		wr(nco_pkg::OFF_SSEL, 32'h0000_0700);
		wr(nco_pkg::OFF_CTRL, 32'h0000_0010);
		rd(nco_pkg::OFF_ACC_A);
		chk({v[23:0], v[31:24] != 8'h00}, {24'h000000, 1'b1});
		// All-ones word steps the accumulator down from zero
		wr(nco_pkg::OFF_TUNE_A_LO, 32'h0000_ffff);
		wr(nco_pkg::OFF_TUNE_A_HI, 32'h0000_ffff);
		wr(nco_pkg::OFF_SSEL, 32'h0000_0101);
		wr(nco_pkg::OFF_SSEL, 32'h0000_0100);
		rd(nco_pkg::OFF_ACC_A);
		chk(v[31:8], 24'hffffff);
		// Clear source codes: never, always, then each external line
		for (int c = 0; c < 7; c++) begin
			wr(nco_pkg::OFF_SSEL, 32'h0000_0100 | 32'(c));
			sync <= (c < 2) ? 5'h1f : 5'(1 << (c - 2));
			wait_cyc(3);
			rd(nco_pkg::OFF_ACC_A);
			chk(v == 32'h0, c != 0);
			sync <= 5'h00;
			rd(nco_pkg::OFF_ACC_A);
			chk(v == 32'h0, c == 1);
		end
		// Offset waits for the phase sync; accumulator held at zero
		wr(nco_pkg::OFF_SSEL, 32'h0000_0101);
		wr(nco_pkg::OFF_OFFS_A, 32'h0000_4000);
		wait_cyc(4);
		chk(ca, rows[0].c);
		wr(nco_pkg::OFF_SSEL, 32'h0000_1101);
		foreach (rows[i]) begin
			wr(nco_pkg::OFF_OFFS_A, {16'h0000, rows[i].offs});
			wait_cyc(4);
			chk(sa, rows[i].s);
			chk(ca, rows[i].c);
			chk(sb, rows[i].s);
			chk(cb, rows[i].c);
			chk(mo[31:0], rows[i].c);
		end
		wr(nco_pkg::OFF_OFFS_A, 32'h0000_0004);
		wait_cyc(4);
		chk(ca, rows[0].c);
		// B offset ignored in single mode, applied in dual mode
		wr(nco_pkg::OFF_OFFS_B, 32'h0000_8000);
		wait_cyc(4);
		chk(cb, rows[0].c);
		wr(nco_pkg::OFF_CTRL, 32'h0000_0001);
		wait_cyc(4);
		chk(ca, rows[0].c);
		chk(cb, rows[2].c);
		chk(sb, rows[2].s);
		// Dither with full trim stays below the table index
		wr(nco_pkg::OFF_CTRL, 32'h0000_000f);
		wait_cyc(4);
		chk(ca, rows[0].c);
		wr(nco_pkg::OFF_SSEL, 32'h0000_1111);
		rd(nco_pkg::OFF_DITH_ST);
		chk(v, {16'h0000, nco_pkg::LFSR_SEED});
		wr(nco_pkg::OFF_SSEL, 32'h0000_1101);
		rd(nco_pkg::OFF_DITH_ST);
		chk(v == {16'h0000, nco_pkg::LFSR_SEED}, 1'b0);
		// Unmapped read and read-only write
		rd(6'h28);
		chk(v, 32'h0000_0000);
		chk(r, nco_pkg::RESP_SLVERR);
		wr(nco_pkg::OFF_ACC_A, 32'h0000_0001);
		chk(r, nco_pkg::RESP_SLVERR);
		// Reset in mid-run returns outputs and registers to rest
		rstn <= 1'b0;
		@(posedge clk);
		chk({ca, awr, wr_rdy, arr}, 32'h0000_0000);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(nco_pkg::OFF_CTRL);
		chk(v, nco_pkg::CTRL_RST);
		chk(ca, rows[0].c);
		close_out();
	end
endmodule : dual_channel_nco_bench
`default_nettype wire
